// >>> rtl/prc_param_request.sv
// Behaviour
// [R1] host frame: 01h, 00h, 02h, 52h, identifier, checksum, 03h
// [R2] bytes before a start byte 01h are dropped
// [R3] missing end byte 03h gives packet error, no execution
// [R4] checksum mismatch gives checksum error, no execution
// [R5] length outside generic format gives packet error
// [R6] length not 00h 02h gives packet error
// [R7] after any error, back to waiting for a start byte
// [R8] identifiers 01h to 04h accepted, others give parameter error
// [R9] identifiers 01h-03h allowed after encrypted write, 04h not until reset
// [R10] restricted identifier after encrypted write gives acceptance error
// [R11] good reply: 81h, 00h, 02h, 52h, value, checksum, 03h
// [R12] value 00h when function disabled, 07h when enabled
// [R13] value bits 2..0 are 000b or 111b, bits 7..3 zero
// [R14] error reply: 81h, 00h, 0Ah, D2h, status, 8 detail bytes, checksum, 03h
// [R15] only highest-priority error reported; detail bytes all FFh
// [R16] request never changes stored memory
// [R17] level-2 key disabled also refuses initialization and return-to-maker
// [R18] a disabled function never reads back as enabled
// [R19] length, payload and checksum bytes sum to zero modulo 256
`default_nettype none
module prc_param_request
    import prc_pkg::*;
#(
    parameter logic [15:0] MAX_BODY = PRC_MAX_BODY
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic                     ce,
    input  wire logic                     rx_valid,
    input  wire logic [7:0]               rx_data,
    output logic                          rx_ready,
    output logic                          tx_valid,
    output logic [7:0]                    tx_data,
    input  wire logic                     tx_ready,
    input  wire logic [PRC_NUM_FUNCS-1:0] func_disabled,
    input  wire logic                     enc_write_done,
    output logic [PRC_NUM_FUNCS-1:0]      func_disabled_seen,
    output logic                          init_refused,
    output logic                          rma_refused
);
    if (MAX_BODY < 16'h0002) begin : g_chk
        $error("MAX_BODY must allow the two-byte body");
    end

    typedef struct packed {
        prc_state_e                        st;
        logic [15:0]                       len;
        logic [15:0]                       pos;
        logic [7:0]                        cmd;
        logic [7:0]                        param_id;
        logic                              fmt_bad;
        logic [PRC_ERR_BYTES-1:0][7:0]     buf_b;
        logic [3:0]                        tx_len;
        logic [3:0]                        tx_idx;
        logic                              tx_valid;
        logic [7:0]                        tx_data;
        logic                              rx_ready;
        logic                              init_refused;
        logic                              rma_refused;
        logic [PRC_NUM_FUNCS-1:0]          dis;
    } prc_core_s;

    prc_core_s                s_r;
    prc_core_s                s_nxt;
    logic                     rx_take;
    logic                     sum_clr;
    logic                     sum_add;
    logic [7:0]               rx_sum;
    logic [PRC_NUM_FUNCS-1:0] dis_q;
    logic                     enc_written;
    logic                     end_ok;
    logic                     sum_ok;
    logic                     cmd_len_ok;
    logic                     id_ok;
    logic                     id_restricted;
    logic                     respond;
    logic                     is_err;
    logic [7:0]               err_code;
    logic [7:0]               val;
    logic [7:0]               csum;

    assign rx_take = rx_valid && s_r.rx_ready;
    assign sum_clr = rx_take && (s_r.st == PRC_WAIT);
    assign sum_add = rx_take && (s_r.st inside {PRC_GET_LEN_HI, PRC_GET_LEN_LO, PRC_BODY, PRC_SUM});

    prc_sum8 u_rx_sum (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .clr      (sum_clr),
        .add      (sum_add),
        .din      (rx_data),
        .sum      (rx_sum)
    );

    // disabled state only ever accumulates
    for (genvar g = 0; g < PRC_NUM_FUNCS; g++) begin : g_dis
        prc_sticky u_dis (
            .core_clk (core_clk),
            .rst      (rst),
            .ce       (ce),
            .set      (func_disabled[g]),
            .q        (dis_q[g])
        ); // R18
    end

    // cleared only by device reset
    prc_sticky u_enc (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .set      (enc_write_done),
        .q        (enc_written)
    ); // R9

    // frame checks evaluated while the end byte is taken
    always_comb begin
        end_ok        = (rx_data == PRC_END_BYTE); // R3
        sum_ok        = (rx_sum == 8'h00); // R4 R19
        cmd_len_ok    = (s_r.len == {PRC_LEN_HI, PRC_LEN_LO_OK}); // R6
        id_ok         = (s_r.param_id >= PRC_ID_INIT) && (s_r.param_id <= PRC_ID_L1KEY); // R8
        id_restricted = (s_r.param_id == PRC_ID_L1KEY) && enc_written; // R9 R10
        respond       = s_r.fmt_bad || (s_r.cmd == PRC_CMD_CODE);
        is_err        = 1'b1;
        err_code      = PRC_CODE_PACKET;
        if (!end_ok) begin
            err_code = PRC_CODE_PACKET; // R15
        end else if (!sum_ok) begin
            err_code = PRC_CODE_CHECKSUM;
        end else if (s_r.fmt_bad) begin
            err_code = PRC_CODE_PACKET; // R5
        end else if (!cmd_len_ok) begin
            err_code = PRC_CODE_PACKET;
        end else if (!id_ok) begin
            err_code = PRC_CODE_PARAM;
        end else if (id_restricted) begin
            err_code = PRC_CODE_ACCEPT;
        end else begin
            is_err = 1'b0;
        end
        val = PRC_VAL_ENABLED;
        if (id_ok && s_r.dis[2'(s_r.param_id - 8'h01)]) begin
            val = PRC_VAL_DISABLED; // R12 R13
        end
        if (is_err) begin
            csum = 8'(8'h00 - PRC_LEN_HI - PRC_LEN_LO_ERR - PRC_RSP_ERR - err_code
                     - 8'(PRC_DETAIL_CNT) * PRC_DETAIL_BYTE);
        end else begin
            csum = 8'(8'h00 - PRC_LEN_HI - PRC_LEN_LO_OK - PRC_RSP_OK - val); // R19
        end
    end

    always_comb begin
        s_nxt              = s_r;
        s_nxt.dis          = dis_q;
        s_nxt.init_refused = dis_q[0] || dis_q[2]; // R17
        s_nxt.rma_refused  = dis_q[2]; // R17
        case (s_r.st)
            PRC_WAIT: begin
                if (rx_take && rx_data == PRC_REQ_START) begin
                    s_nxt.st       = PRC_GET_LEN_HI; // R2
                    s_nxt.cmd      = 8'h00;
                    s_nxt.param_id = 8'h00;
                    s_nxt.fmt_bad = 1'b0;
                    s_nxt.pos     = 16'h0000;
                end
            end
            PRC_GET_LEN_HI: begin
                if (rx_take) begin
                    s_nxt.len[15:8] = rx_data;
                    s_nxt.st        = PRC_GET_LEN_LO;
                end
            end
            PRC_GET_LEN_LO: begin
                if (rx_take) begin
                    s_nxt.len[7:0] = rx_data;
                    if ({s_r.len[15:8], rx_data} == 16'h0000 ||
                        {s_r.len[15:8], rx_data} > MAX_BODY) begin
                        s_nxt.fmt_bad = 1'b1; // R5
                        s_nxt.st      = PRC_SUM;
                    end else begin
                        s_nxt.st = PRC_BODY;
                    end
                end
            end
            PRC_BODY: begin
                if (rx_take) begin
                    if (s_r.pos == 16'h0000) begin
                        s_nxt.cmd = rx_data;
                    end
                    if (s_r.pos == 16'h0001) begin
                        s_nxt.param_id = rx_data;
                    end
                    s_nxt.pos = 16'(s_r.pos + 16'h0001);
                    if (s_r.pos == 16'(s_r.len - 16'h0001)) begin
                        s_nxt.st = PRC_SUM;
                    end
                end
            end
            PRC_SUM: begin
                if (rx_take) begin
                    s_nxt.st = PRC_END;
                end
            end
            PRC_END: begin
                if (rx_take) begin
                    if (!respond) begin
                        s_nxt.st = PRC_WAIT;
                    end else begin
                        s_nxt.st       = PRC_SEND;
                        s_nxt.rx_ready = 1'b0;
                        s_nxt.tx_idx   = 4'h0;
                        s_nxt.tx_valid = 1'b1;
                        s_nxt.tx_data  = PRC_REPLY_START;
                        s_nxt.buf_b    = '1;
                        s_nxt.buf_b[0] = PRC_REPLY_START;
                        s_nxt.buf_b[1] = PRC_LEN_HI;
                        if (is_err) begin
                            s_nxt.tx_len   = PRC_ERR_LEN; // R14
                            s_nxt.buf_b[2] = PRC_LEN_LO_ERR;
                            s_nxt.buf_b[3] = PRC_RSP_ERR;
                            s_nxt.buf_b[4] = err_code;
                            for (int i = 0; i < PRC_DETAIL_CNT; i++) begin
                                s_nxt.buf_b[PRC_ERR_DET_POS + i] = PRC_DETAIL_BYTE; // R15
                            end
                            s_nxt.buf_b[PRC_ERR_SUM_POS]     = csum;
                            s_nxt.buf_b[PRC_ERR_SUM_POS + 1] = PRC_END_BYTE;
                        end else begin
                            s_nxt.tx_len   = PRC_OK_LEN; // R11
                            s_nxt.buf_b[2] = PRC_LEN_LO_OK;
                            s_nxt.buf_b[3] = PRC_RSP_OK;
                            s_nxt.buf_b[4] = val;
                            s_nxt.buf_b[PRC_OK_SUM_POS]     = csum;
                            s_nxt.buf_b[PRC_OK_SUM_POS + 1] = PRC_END_BYTE;
                        end
                    end
                end
            end
            PRC_SEND: begin
                if (s_r.tx_valid && tx_ready) begin
                    if (s_r.tx_idx == 4'(s_r.tx_len - 4'h1)) begin
                        s_nxt.tx_valid = 1'b0;
                        s_nxt.rx_ready = 1'b1;
                        s_nxt.st       = PRC_WAIT; // R7
                    end else begin
                        s_nxt.tx_idx  = 4'(s_r.tx_idx + 4'h1);
                        s_nxt.tx_data = s_r.buf_b[4'(s_r.tx_idx + 4'h1)];
                    end
                end
            end
            default: begin
                s_nxt.st       = PRC_WAIT;
                s_nxt.tx_valid = 1'b0;
                s_nxt.rx_ready = 1'b1;
            end
        endcase
    end

    // no write path to storage exists in this block
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_r          <= '0;
            s_r.st       <= PRC_WAIT;
            s_r.rx_ready <= 1'b1;
        end else if (ce) begin
            s_r <= s_nxt; // R16
        end
    end

    assign rx_ready           = s_r.rx_ready;
    assign tx_valid           = s_r.tx_valid;
    assign tx_data            = s_r.tx_data;
    assign func_disabled_seen = s_r.dis;
    assign init_refused       = s_r.init_refused;
    assign rma_refused        = s_r.rma_refused;

    // checks
    logic take_end;
    assign take_end = ce && rx_take && (s_r.st == PRC_END) && respond;

    a_start_discard: assert property (@(posedge core_clk) disable iff (rst) // R2
        (ce && s_r.st == PRC_WAIT && rx_valid && rx_data != PRC_REQ_START) |=> s_r.st == PRC_WAIT)
        else $error("non-start byte left the wait state");
    a_end_missing: assert property (@(posedge core_clk) disable iff (rst) // R3
        (take_end && rx_data != PRC_END_BYTE) |=> s_r.buf_b[4] == PRC_CODE_PACKET
        && s_r.buf_b[3] == PRC_RSP_ERR)
        else $error("missing end byte not reported as packet error");
    a_sum_error: assert property (@(posedge core_clk) disable iff (rst) // R4
        (take_end && end_ok && rx_sum != 8'h00) |=> s_r.buf_b[4] == PRC_CODE_CHECKSUM)
        else $error("checksum error not reported");
    a_cmd_len: assert property (@(posedge core_clk) disable iff (rst) // R6
        (take_end && end_ok && sum_ok && !s_r.fmt_bad && !cmd_len_ok)
        |=> s_r.buf_b[4] == PRC_CODE_PACKET)
        else $error("command length error not reported");
    a_bad_id: assert property (@(posedge core_clk) disable iff (rst) // R8
        (take_end && end_ok && sum_ok && cmd_len_ok && !id_ok) |=> s_r.buf_b[4] == PRC_CODE_PARAM)
        else $error("unsupported identifier not reported");
    a_post_write: assert property (@(posedge core_clk) disable iff (rst) // R10
        (take_end && end_ok && sum_ok && cmd_len_ok && s_r.param_id == PRC_ID_L1KEY
        && enc_written) |=> s_r.buf_b[4] == PRC_CODE_ACCEPT)
        else $error("restricted identifier after encrypted write accepted");
    a_value_byte: assert property (@(posedge core_clk) disable iff (rst) // R12
        (take_end && !is_err) |=> s_r.tx_len == PRC_OK_LEN
        && (s_r.buf_b[4] == PRC_VAL_ENABLED || s_r.buf_b[4] == PRC_VAL_DISABLED))
        else $error("value byte malformed");
    a_reply_start: assert property (@(posedge core_clk) disable iff (rst) // R11
        $rose(tx_valid) |-> tx_data == PRC_REPLY_START ##0 !rx_ready)
        else $error("reply does not open with start byte");
    a_tx_hold: assert property (@(posedge core_clk) disable iff (rst) // R14
        (tx_valid && !tx_ready) |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped under back-pressure");
    a_refuse_init: assert property (@(posedge core_clk) disable iff (rst) // R17
        (ce && dis_q[2]) |=> init_refused && rma_refused)
        else $error("level-2 disable did not refuse init");
    a_error_back: assert property (@(posedge core_clk) disable iff (rst) // R7
        (ce && s_r.st == PRC_SEND && tx_valid && tx_ready && s_r.tx_idx == 4'(s_r.tx_len - 4'h1))
        |=> s_r.st == PRC_WAIT && rx_ready && !tx_valid)
        else $error("did not return to waiting after reply");
    a_silent_drop: assert property (@(posedge core_clk) disable iff (rst) // R7
        (ce && rx_take && s_r.st == PRC_END && !respond) |=> s_r.st == PRC_WAIT && !tx_valid)
        else $error("dropped frame produced a reply");
    a_fmt_len: assert property (@(posedge core_clk) disable iff (rst) // R5
        (take_end && end_ok && sum_ok && s_r.fmt_bad) |=> s_r.buf_b[4] == PRC_CODE_PACKET)
        else $error("format length error not reported");
    a_value_bits: assert property (@(posedge core_clk) disable iff (rst) // R13
        (take_end && !is_err) |=> s_r.buf_b[4][7:3] == 5'h00)
        else $error("value byte upper bits not zero");
    a_err_detail: assert property (@(posedge core_clk) disable iff (rst) // R15
        (take_end && is_err) |=> s_r.tx_len == PRC_ERR_LEN
        && s_r.buf_b[PRC_ERR_SUM_POS-1:PRC_ERR_DET_POS] == '1)
        else $error("error detail bytes not all ones");
    a_freeze: assert property (@(posedge core_clk) disable iff (rst)
        !ce |=> $stable(s_r))
        else $error("state moved while clock enable low");

    c_ok_reply: cover property (@(posedge core_clk) disable iff (rst) take_end && !is_err);
    c_err_reply: cover property (@(posedge core_clk) disable iff (rst) take_end && is_err);
    c_restricted: cover property (@(posedge core_clk) disable iff (rst)
        take_end && err_code == PRC_CODE_ACCEPT);
    c_fmt_error: cover property (@(posedge core_clk) disable iff (rst) take_end && s_r.fmt_bad);
    c_disabled_read: cover property (@(posedge core_clk) disable iff (rst)
        take_end && !is_err && val == PRC_VAL_DISABLED);
endmodule
`default_nettype wire

// >>> rtl/prc_pkg.sv
`default_nettype none
package prc_pkg;
    // frame bytes
    localparam logic [7:0] PRC_REQ_START    = 8'h01;
    localparam logic [7:0] PRC_REPLY_START  = 8'h81;
    localparam logic [7:0] PRC_END_BYTE     = 8'h03;
    localparam logic [7:0] PRC_CMD_CODE     = 8'h52;
    localparam logic [7:0] PRC_RSP_OK       = 8'h52;
    localparam logic [7:0] PRC_RSP_ERR      = 8'hD2;
    localparam logic [7:0] PRC_LEN_HI       = 8'h00;
    localparam logic [7:0] PRC_LEN_LO_OK    = 8'h02;
    localparam logic [7:0] PRC_LEN_LO_ERR   = 8'h0A;
    localparam logic [7:0] PRC_DETAIL_BYTE  = 8'hFF;
    // value byte: bits 2..0 carry the state, bits 7..3 stay zero
    localparam logic [7:0] PRC_VAL_ENABLED  = 8'h07;
    localparam logic [7:0] PRC_VAL_DISABLED = 8'h00;
    // status codes (arbitrary encodings)
    localparam logic [7:0] PRC_CODE_PACKET   = 8'hC1;
    localparam logic [7:0] PRC_CODE_CHECKSUM = 8'hC2;
    localparam logic [7:0] PRC_CODE_PARAM    = 8'hC3;
    localparam logic [7:0] PRC_CODE_ACCEPT   = 8'hC4;
    // identifiers
    localparam logic [7:0] PRC_ID_INIT      = 8'h01;
    localparam logic [7:0] PRC_ID_LOCKBOOT  = 8'h02;
    localparam logic [7:0] PRC_ID_L2KEY     = 8'h03;
    localparam logic [7:0] PRC_ID_L1KEY     = 8'h04;
    // reply layout
    localparam int         PRC_NUM_FUNCS    = 4;
    localparam int         PRC_ERR_BYTES    = 15;
    localparam logic [3:0] PRC_OK_LEN       = 4'h7;
    localparam logic [3:0] PRC_ERR_LEN      = 4'hF;
    localparam int         PRC_OK_SUM_POS   = 5;
    localparam int         PRC_ERR_SUM_POS  = 13;
    localparam int         PRC_ERR_DET_POS  = 5;
    localparam int         PRC_DETAIL_CNT   = 8;
    localparam logic [15:0] PRC_MAX_BODY    = 16'h0400;

    typedef enum logic [2:0] {
        PRC_WAIT, PRC_GET_LEN_HI, PRC_GET_LEN_LO, PRC_BODY, PRC_SUM, PRC_END, PRC_SEND
    } prc_state_e;

    typedef struct packed {
        logic [7:0] acc;
    } prc_sum_s;

    typedef struct packed {
        logic q;
    } prc_sticky_s;
endpackage
`default_nettype wire

// >>> rtl/prc_sum8.sv
`default_nettype none
module prc_sum8
    import prc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       clr,
    input  wire logic       add,
    input  wire logic [7:0] din,
    output logic      [7:0] sum
);
    prc_sum_s s_r;
    prc_sum_s s_nxt;

    // modulo-256 running sum
    always_comb begin
        s_nxt = s_r;
        if (clr) begin
            s_nxt.acc = 8'h00;
        end else if (add) begin
            s_nxt.acc = 8'(s_r.acc + din);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign sum = s_r.acc;
endmodule
`default_nettype wire

// >>> rtl/prc_sticky.sv
`default_nettype none
module prc_sticky
    import prc_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic set,
    output logic      q
);
    prc_sticky_s s_r;
    prc_sticky_s s_nxt;

    // once set, only a reset clears it
    always_comb begin
        s_nxt = s_r;
        if (set) begin
            s_nxt.q = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.q;
endmodule
`default_nettype wire

// >>> verif/prc_host_model.sv
`default_nettype none
module prc_host_model
    import prc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rx_ready,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    output logic            tx_ready
);
    timeunit 1ns;
    timeprecision 1ns;

    bit slow = 1'b0;

    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b0;
    end

    // length bytes, body, zero-sum checksum, end byte
    function automatic void build(input logic [7:0] start, input logic [7:0] body[$],
                                  output logic [7:0] f[$]);
        logic [7:0] s;
        f = {start, 8'h00, 8'(body.size())};
        s = 8'(body.size());
        foreach (body[i]) begin
            f.push_back(body[i]);
            s += body[i];
        end
        f.push_back(8'h00 - s);
        f.push_back(PRC_END_BYTE);
    endfunction

    // each byte held until the edge that takes it; released line shows inverse
    task automatic send(input logic [7:0] f[$], output bit ok);
        int n;
        ok = 1'b1;
        foreach (f[i]) begin
            @(negedge core_clk);
            if (slow) begin
                rx_valid = 1'b0;
                rx_data  = ~rx_data;
                @(negedge core_clk);
            end
            rx_valid = 1'b1;
            rx_data  = f[i];
            n = 0;
            while (rx_ready !== 1'b1 && n < 200) begin
                @(negedge core_clk);
                n++;
            end
            if (n >= 200) ok = 1'b0;
            @(posedge core_clk);
        end
        @(negedge core_clk);
        rx_valid = 1'b0;
        rx_data  = ~rx_data;
    endtask

    // slow mode stalls every other cycle
    task automatic recv(input int cnt, output logic [7:0] q[$], output bit ok);
        int n;
        q = {};
        n = 0;
        while (q.size() < cnt && n < 400) begin
            @(negedge core_clk);
            tx_ready = slow ? ~tx_ready : 1'b1;
            if (tx_valid === 1'b1 && tx_ready) q.push_back(tx_data);
            n++;
        end
        @(negedge core_clk);
        tx_ready = 1'b0;
        ok = (q.size() == cnt);
    endtask
endmodule
`default_nettype wire

// >>> verif/prc_param_request_tb.sv
`default_nettype none
module prc_param_request_tb
    import prc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef logic [7:0] prc_bytes_t[$];

    logic                     core_clk, rst, ce, rx_valid, rx_ready, tx_valid, tx_ready;
    logic                     enc_write_done, init_refused, rma_refused;
    logic [7:0]               rx_data, tx_data;
    logic [PRC_NUM_FUNCS-1:0] func_disabled, func_disabled_seen;
    int                       err_count, checks_done;

    prc_param_request #(.MAX_BODY(16'h0400)) dut (
        .core_clk(core_clk), .rst(rst), .ce(ce),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .func_disabled(func_disabled), .enc_write_done(enc_write_done),
        .func_disabled_seen(func_disabled_seen),
        .init_refused(init_refused), .rma_refused(rma_refused)
    );

    prc_host_model host (
        .core_clk(core_clk), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready)
    );

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic timed_out();
        err_count++;
        $display("[ERR] handshake expected completion seen timeout");
        summarize();
    endtask

    function automatic prc_bytes_t frame(input logic [7:0] start, input prc_bytes_t body);
        prc_bytes_t f;
        host.build(start, body, f);
        return f;
    endfunction

    function automatic prc_bytes_t req(input logic [7:0] id);
        return frame(8'h01, {8'h52, id});
    endfunction

    function automatic prc_bytes_t ok_reply(input logic [7:0] val);
        return frame(8'h81, {8'h52, val});
    endfunction

    // status code then eight all-ones detail bytes
    function automatic prc_bytes_t err_reply(input logic [7:0] code);
        prc_bytes_t b;
        b = {8'hD2, code};
        repeat (8) b.push_back(8'hFF);
        return frame(8'h81, b);
    endfunction

    task automatic xact(input prc_bytes_t f, input prc_bytes_t e);
        prc_bytes_t got;
        bit         ok;
        host.send(f, ok);
        if (ok) host.recv(e.size(), got, ok);
        if (!ok) begin
            timed_out();
        end else begin
            foreach (e[i]) check("reply byte", got[i], e[i]);
            check("tx_valid after reply", {7'h0, tx_valid}, 8'h00);
            check("rx_ready after reply", {7'h0, rx_ready}, 8'h01);
        end
    endtask

    task automatic s_good_reads();
        bit ok;
        host.send({8'h55, 8'h03, 8'h81, 8'hAA}, ok);
        if (!ok) timed_out();
        for (int i = 1; i <= 4; i++) xact(req(8'(i)), ok_reply(8'h07));
        check("disabled seen", {4'h0, func_disabled_seen}, 8'h00);
    endtask

    task automatic s_errors();
        prc_bytes_t f;
        f = req(8'h01);
        f[6] = 8'h55;
        xact(f, err_reply(PRC_CODE_PACKET));
        f[5] = f[5] ^ 8'h01;
        xact(f, err_reply(PRC_CODE_PACKET));
        f = req(8'h01);
        f[5] = f[5] ^ 8'h01;
        xact(f, err_reply(PRC_CODE_CHECKSUM));
        xact({8'h01, 8'h00, 8'h00, 8'h00, 8'h03}, err_reply(PRC_CODE_PACKET));
        xact({8'h01, 8'h04, 8'h01, 8'hFB, 8'h03}, err_reply(PRC_CODE_PACKET));
        f = frame(8'h01, {8'h52, 8'h01, 8'h00});
        xact(f, err_reply(PRC_CODE_PACKET));
        f[6] = f[6] ^ 8'h01;
        xact(f, err_reply(PRC_CODE_CHECKSUM));
        xact(frame(8'h01, {8'h52}), err_reply(PRC_CODE_PACKET));
        xact(req(8'h05), err_reply(PRC_CODE_PARAM));
        xact(req(8'h00), err_reply(PRC_CODE_PARAM));
        xact(req(8'h02), ok_reply(8'h07));
    endtask

    task automatic s_write_restrict();
        host.slow = 1'b1;
        @(negedge core_clk);
        enc_write_done = 1'b1;
        @(negedge core_clk);
        enc_write_done = 1'b0;
        for (int i = 1; i <= 3; i++) xact(req(8'(i)), ok_reply(8'h07));
        xact(req(8'h04), err_reply(PRC_CODE_ACCEPT));
        xact(req(8'h05), err_reply(PRC_CODE_PARAM));
        // device reset lifts the post-write restriction
        @(negedge core_clk);
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        check("rx_ready in reset", {7'h0, rx_ready}, 8'h01);
        rst = 1'b0;
        xact(req(8'h04), ok_reply(8'h07));
        host.slow = 1'b0;
    endtask

    task automatic pulse_dis(input logic [3:0] m);
        @(negedge core_clk);
        func_disabled = m;
        @(negedge core_clk);
        func_disabled = 4'h0;
        repeat (3) @(negedge core_clk);
    endtask

    task automatic s_disable();
        pulse_dis(4'h1);
        check("disabled seen", {4'h0, func_disabled_seen}, 8'h01);
        check("rma refused", {7'h0, rma_refused}, 8'h00);
        xact(req(8'h01), ok_reply(8'h00));
        pulse_dis(4'h4);
        check("init refused", {7'h0, init_refused}, 8'h01);
        check("rma refused", {7'h0, rma_refused}, 8'h01);
        xact(req(8'h03), ok_reply(8'h00));
        xact(req(8'h01), ok_reply(8'h00));
        xact(req(8'h02), ok_reply(8'h07));
    endtask

    // disable levels offered while clock enable is low are not latched
    task automatic s_freeze();
        @(negedge core_clk);
        ce = 1'b0;
        func_disabled = 4'h8;
        repeat (3) @(negedge core_clk);
        func_disabled = 4'h0;
        ce = 1'b1;
        repeat (3) @(negedge core_clk);
        check("frozen seen", {4'h0, func_disabled_seen}, 8'h05);
        xact(req(8'h04), ok_reply(8'h07));
        pulse_dis(4'h8);
        xact(req(8'h04), ok_reply(8'h00));
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        func_disabled = 4'h0;
        enc_write_done = 1'b0;
        repeat (20) @(posedge core_clk);
        check("tx_valid in reset", {7'h0, tx_valid}, 8'h00);
        @(negedge core_clk);
        rst = 1'b0;
        s_good_reads();
        s_errors();
        s_write_restrict();
        s_disable();
        s_freeze();
        summarize();
    end
endmodule
`default_nettype wire
